// *** verilog/hc_power_pkg.sv ***
`default_nettype none
package hc_power_pkg;
  // bus word offsets (byte addresses, aligned words)
  localparam logic [3:0] OFF_HW_CONFIG   = 4'h0;
  localparam logic [3:0] OFF_HOST_CTRL   = 4'h4;
  localparam logic [3:0] OFF_EVENT_STAT  = 4'h8;
  localparam logic [3:0] OFF_PROC_INT    = 4'hC;
  // hardware config fields
  localparam int unsigned BIT_INT_OC     = 10;
  localparam int unsigned BIT_KEEP_CLK   = 11;
  localparam int unsigned BIT_INT_PD     = 12;
  // host control functional state, bits 7:6
  localparam int unsigned FS_LSB         = 6;
  localparam logic [1:0]  FS_RESET       = 2'h0;
  localparam logic [1:0]  FS_RESUME      = 2'h1;
  localparam logic [1:0]  FS_OPER        = 2'h2;
  localparam logic [1:0]  FS_SUSPEND     = 2'h3;
  // status bit positions
  localparam int unsigned BIT_RESUME_SEEN = 6;
  localparam int unsigned BIT_CLK_READY   = 6;
  // reset values
  localparam logic [15:0] HW_CONFIG_RST  = 16'h0000;
  localparam logic [1:0]  FS_RST         = 2'h0;
  // timing, clock 25 MHz
  localparam int unsigned CLK_KHZ        = 25000;
  localparam int unsigned SUSP_STOP_US10 = 13000;
  localparam int unsigned WAKE_UP_US     = 160;
  localparam int unsigned WAKE_LOW_US100 = 114;
  localparam int unsigned SUSP_STOP_CYC  = SUSP_STOP_US10 * (CLK_KHZ / 1000) / 10;
  localparam int unsigned WAKE_UP_CYC    = WAKE_UP_US * (CLK_KHZ / 1000);
  localparam int unsigned WAKE_LOW_CYC   = WAKE_LOW_US100 * (CLK_KHZ / 100) + 1;
endpackage
`default_nettype wire

// *** verilog/host_port_power_and_suspend_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
// Contract
// - overcurrent drives power switch high
// - two ports, open-drain switch, oc input
// - config bit 10 selects internal detection
// - internal detection bit resets to zero
// - bit 12 connects internal pull-downs
// - functional state write enters suspend
// - full suspend stops clock, PLL, regulator
// - full suspend needs host and device suspended
// - suspended output until reset or operational
// - clock stops 1.3 ms unless keep bit
// - wake pin restarts clock, sets ready
// - clock running 160 us after wake
// - clock held while wake stays high
// - wake low 1.14 ms returns suspend
// - chip select access wakes host
// - usb resume sets resume seen flag
module host_port_power_and_suspend_ctrl #(
  parameter int unsigned SUSP_STOP_CYCLES = hc_power_pkg::SUSP_STOP_CYC,
  parameter int unsigned WAKE_LOW_CYCLES  = hc_power_pkg::WAKE_LOW_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // port pins
  input  wire logic [1:0]  port_overcurrent_n,
  input  wire logic [1:0]  analog_oc_trip,
  output logic [1:0]       port_power_switch_n_o,
  output logic [1:0]       port_power_switch_n_oe,
  output logic             internal_pulldown_on,
  // suspend and wake
  input  wire logic        host_wake_in,
  input  wire logic        chip_select_n,
  input  wire logic        usb_resume_in,
  input  wire logic        device_suspended,
  output logic             host_suspended_out,
  output logic             clock_run,
  output logic             full_suspend,
  output logic             regulator_power_down
);

  // ****************************************
  // state
  // ****************************************
  typedef enum {ST_AWAKE, ST_SUSP, ST_STOPPED, ST_WAKING, ST_WOKEN} clk_state_t;

  typedef struct packed {
    logic [1:0]  oc_s1;
    logic [1:0]  oc_s2;
    logic [1:0]  trip_s1;
    logic [1:0]  trip_s2;
    logic [2:0]  wake_s;
    logic [1:0]  cs_s;
    logic [1:0]  res_s;
    logic [1:0]  dev_s;
    logic [15:0] hw_config;
    logic [1:0]  func_state;
    logic        resume_seen;
    logic        clock_ready;
    clk_state_t  cstate;
    logic [31:0] timer;
    logic [31:0] rdata;
    logic        ack;
    logic        wreq;
    logic [1:0]  psw;
    logic        pd_on;
    logic        susp_out;
    logic        clk_run;
    logic        full_susp;
    logic        reg_pd;
  } state_t;

  state_t cur;
  state_t next_cur;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  logic wake_lvl;
  logic access;
  logic wr_go;
  logic rd_go;
  assign wake_lvl = cur.wake_s[1];
  assign access   = (avs_read || avs_write) && !cur.ack;
  // write lands at the edge where waitrequest is seen low
  assign wr_go    = avs_write && cur.ack;
  assign rd_go    = avs_read && !cur.ack;

  always_comb begin
    next_cur = cur;
    next_cur.oc_s1   = ~port_overcurrent_n;
    next_cur.oc_s2   = cur.oc_s1;
    next_cur.trip_s1 = analog_oc_trip;
    next_cur.trip_s2 = cur.trip_s1;
    next_cur.wake_s  = {cur.wake_s[1:0], host_wake_in};
    next_cur.cs_s    = {cur.cs_s[0], ~chip_select_n};
    next_cur.res_s   = {cur.res_s[0], usb_resume_in};
    next_cur.dev_s   = {cur.dev_s[0], device_suspended};

    // ****************************************
    // register bus
    // ****************************************
    next_cur.ack  = access;
    next_cur.wreq = !access;
    if (rd_go) begin
      if (hit(avs_address, hc_power_pkg::OFF_HW_CONFIG)) begin
        next_cur.rdata = {16'h0000, cur.hw_config};
      end else if (hit(avs_address, hc_power_pkg::OFF_HOST_CTRL)) begin
        next_cur.rdata = {24'h000000, cur.func_state, 6'h00};
      end else if (hit(avs_address, hc_power_pkg::OFF_EVENT_STAT)) begin
        next_cur.rdata = {25'h0000000, cur.resume_seen, 6'h00};
      end else if (hit(avs_address, hc_power_pkg::OFF_PROC_INT)) begin
        next_cur.rdata = {25'h0000000, cur.clock_ready, 6'h00};
      end else begin
        next_cur.rdata = 32'h00000000;
      end
    end
    if (wr_go) begin
      if (hit(avs_address, hc_power_pkg::OFF_HW_CONFIG)) begin
        next_cur.hw_config = avs_writedata[15:0];
      end
      if (hit(avs_address, hc_power_pkg::OFF_HOST_CTRL)) begin
        next_cur.func_state = avs_writedata[hc_power_pkg::FS_LSB +: 2];
      end
      // write one to clear; a same-cycle set below wins
      if (hit(avs_address, hc_power_pkg::OFF_EVENT_STAT) && avs_writedata[hc_power_pkg::BIT_RESUME_SEEN]) begin
        next_cur.resume_seen = 1'b0;
      end
      if (hit(avs_address, hc_power_pkg::OFF_PROC_INT) && avs_writedata[hc_power_pkg::BIT_CLK_READY]) begin
        next_cur.clock_ready = 1'b0;
      end
    end

    // ****************************************
    // power switching
    // ****************************************
    // switch off on overcurrent, per port, source select
    for (int i = 0; i < 2; i++) begin
      next_cur.psw[i] = ~(cur.hw_config[hc_power_pkg::BIT_INT_OC] ? cur.trip_s2[i] : cur.oc_s2[i]);
    end
    next_cur.pd_on = cur.hw_config[hc_power_pkg::BIT_INT_PD];

    // ****************************************
    // suspend clock control
    // ****************************************
    next_cur.timer = cur.timer + 32'h00000001;
    case (cur.cstate)
      ST_AWAKE: begin
        next_cur.timer = 32'h00000000;
        if (cur.func_state == hc_power_pkg::FS_SUSPEND) begin
          next_cur.cstate = ST_SUSP;
        end
      end
      ST_SUSP: begin
        // stop after dwell unless keep bit
        if (cur.hw_config[hc_power_pkg::BIT_KEEP_CLK]) begin
          next_cur.timer = 32'h00000000;
        end else if (cur.timer >= SUSP_STOP_CYCLES - 1) begin
          next_cur.cstate = ST_STOPPED;
          next_cur.timer  = 32'h00000000;
        end
      end
      ST_STOPPED: begin
        next_cur.timer = 32'h00000000;
        if (wake_lvl) begin
          next_cur.cstate = ST_WAKING;
        end
      end
      ST_WAKING: begin
        if (cur.timer >= hc_power_pkg::WAKE_UP_CYC - 1) begin
          next_cur.cstate = ST_WOKEN;
          next_cur.timer  = 32'h00000000;
          next_cur.clock_ready = 1'b1;
        end
      end
      ST_WOKEN: begin
        // held while wake high; low too long re-stops
        if (wake_lvl) begin
          next_cur.timer = 32'h00000000;
        end else if (cur.timer >= WAKE_LOW_CYCLES - 1) begin
          next_cur.cstate = ST_STOPPED;
          next_cur.timer  = 32'h00000000;
        end
      end
      default: next_cur.cstate = ST_AWAKE;
    endcase
    // chip select access acts as software wake
    if ((cur.cstate == ST_STOPPED || cur.cstate == ST_SUSP) && cur.cs_s[1]) begin
      next_cur.cstate = ST_WOKEN;
      next_cur.timer  = 32'h00000000;
    end
    if (cur.func_state == hc_power_pkg::FS_SUSPEND && cur.res_s[1]) begin
      next_cur.func_state  = hc_power_pkg::FS_RESUME;
      next_cur.resume_seen = 1'b1;
    end
    if (cur.func_state != hc_power_pkg::FS_SUSPEND && !(wr_go && hit(avs_address, hc_power_pkg::OFF_HOST_CTRL))) begin
      next_cur.cstate = ST_AWAKE;
    end

    // suspended output set on entry, cleared on reset or operational
    if (cur.func_state == hc_power_pkg::FS_SUSPEND) begin
      next_cur.susp_out = 1'b1;
    end else if (cur.func_state == hc_power_pkg::FS_RESET || cur.func_state == hc_power_pkg::FS_OPER) begin
      next_cur.susp_out = 1'b0;
    end
    // clock off while stopped
    // clock not counted as running until the wake-up delay is over
    next_cur.clk_run   = !(next_cur.cstate == ST_STOPPED || next_cur.cstate == ST_WAKING);
    // full suspend needs both controllers suspended
    next_cur.full_susp = (next_cur.cstate == ST_STOPPED) && cur.dev_s[1];
    next_cur.reg_pd    = next_cur.full_susp;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.wreq       <= 1'b1;
      cur.hw_config  <= hc_power_pkg::HW_CONFIG_RST;
      cur.func_state <= hc_power_pkg::FS_RST;
      cur.cstate     <= ST_AWAKE;
      cur.clk_run    <= 1'b1;
    end else if (clk_en || cur.cstate == ST_STOPPED) begin
      // stopped clock modelled by freezing; wake pin still sampled
      cur <= next_cur;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_readdata           = cur.rdata;
  assign avs_waitrequest        = cur.wreq;
  // open-drain: enable pulls low to apply power
  assign port_power_switch_n_o  = 2'h0;
  assign port_power_switch_n_oe = cur.psw;
  assign internal_pulldown_on   = cur.pd_on;
  assign host_suspended_out     = cur.susp_out;
  assign clock_run              = cur.clk_run;
  assign full_suspend           = cur.full_susp;
  assign regulator_power_down   = cur.reg_pd;

  // ****************************************
  // checks
  // ****************************************
  property p_oc_off;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && !cur.hw_config[hc_power_pkg::BIT_INT_OC] && cur.oc_s2[0]) |=> port_power_switch_n_oe[0] == 1'b0;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("power not removed on overcurrent");

  property p_two_ports;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && !cur.hw_config[hc_power_pkg::BIT_INT_OC] && !cur.oc_s2[1]) |=> port_power_switch_n_oe[1];
  endproperty
  a_two_ports: assert property (p_two_ports) else $error("port 2 power not applied");

  property p_int_sel;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && cur.hw_config[hc_power_pkg::BIT_INT_OC]) |=> port_power_switch_n_oe == ~$past(cur.trip_s2);
  endproperty
  a_int_sel: assert property (p_int_sel) else $error("internal detection not used");

  property p_reset_cfg;
    @(posedge sys_clk) $fell(rst) |-> cur.hw_config[hc_power_pkg::BIT_INT_OC] == 1'b0;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("config not reset");

  property p_susp_out;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && cur.func_state == hc_power_pkg::FS_OPER) |=> !host_suspended_out;
  endproperty
  a_susp_out: assert property (p_susp_out) else $error("suspended output stuck");

  property p_keep;
    @(posedge sys_clk) disable iff (rst)
      (cur.hw_config[hc_power_pkg::BIT_KEEP_CLK] && cur.cstate == ST_SUSP) |=> cur.cstate != ST_STOPPED;
  endproperty
  a_keep: assert property (p_keep) else $error("clock stopped despite keep bit");

  logic clock_ready_q;
  assign clock_ready_q = cur.clock_ready;
  property p_ready;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && cur.cstate == ST_WAKING && next_cur.cstate == ST_WOKEN) |=> clock_ready_q;
  endproperty
  a_ready: assert property (p_ready) else $error("clock ready not set");

  property p_pd;
    @(posedge sys_clk) disable iff (rst)
      clk_en |=> internal_pulldown_on == $past(cur.hw_config[hc_power_pkg::BIT_INT_PD]);
  endproperty
  a_pd: assert property (p_pd) else $error("pull-down select ignored");

  property p_full;
    @(posedge sys_clk) disable iff (rst) full_suspend |-> !clock_run;
  endproperty
  a_full: assert property (p_full) else $error("full suspend with clock running");

  c_stop: cover property (@(posedge sys_clk) cur.cstate == ST_STOPPED);
  c_wake: cover property (@(posedge sys_clk) cur.cstate == ST_WOKEN);
  c_oc:   cover property (@(posedge sys_clk) port_power_switch_n_oe == 2'h0);
  c_res:  cover property (@(posedge sys_clk) cur.resume_seen);

endmodule // host_port_power_and_suspend_ctrl
`default_nettype wire

// *** verif/port_switch_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module port_switch_model (
  // design side
  input  wire logic [1:0] sw_o,
  input  wire logic [1:0] sw_oe,
  output logic [1:0]      oc_n,
  output logic [1:0]      oc_trip,
  // bench side
  input  wire logic [1:0] ext_fault,
  input  wire logic [1:0] int_fault,
  output logic [1:0]      vbus_on
);
  logic [1:0] pin;
  assign pin = (sw_oe & sw_o) | ~sw_oe;
  assign vbus_on = ~pin;
  assign oc_n    = ~ext_fault;
  assign oc_trip = int_fault;
endmodule // port_switch_model
`default_nettype wire

// *** verif/host_port_power_and_suspend_ctrl_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_port_power_and_suspend_ctrl_tb;
  localparam int SUSP = 50;
  localparam int WLOW = 40;
  logic        sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest, internal_pulldown_on;
  logic [1:0]  oc_n, oc_trip, sw_o, sw_oe, vbus_on;
  logic [1:0]  ext_fault = 2'h0, int_fault = 2'h0;
  logic        host_wake_in = 1'b0, chip_select_n = 1'b1, usb_resume_in = 1'b0;
  logic        device_suspended = 1'b0, host_suspended_out, clock_run, full_suspend, regulator_power_down;
  logic [31:0] rnd = 32'h5903;
  logic [31:0] exp_q[$];
  int          err_count = 0, checks_done = 0, cyc = 0, i;
  always #20 sys_clk = ~sys_clk;
  host_port_power_and_suspend_ctrl #(.SUSP_STOP_CYCLES(SUSP), .WAKE_LOW_CYCLES(WLOW)) DUT (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_overcurrent_n(oc_n), .analog_oc_trip(oc_trip),
    .port_power_switch_n_o(sw_o), .port_power_switch_n_oe(sw_oe),
    .internal_pulldown_on(internal_pulldown_on), .host_wake_in(host_wake_in),
    .chip_select_n(chip_select_n), .usb_resume_in(usb_resume_in), .device_suspended(device_suspended),
    .host_suspended_out(host_suspended_out), .clock_run(clock_run), .full_suspend(full_suspend),
    .regulator_power_down(regulator_power_down));
  port_switch_model PSW (.sw_o(sw_o), .sw_oe(sw_oe), .oc_n(oc_n), .oc_trip(oc_trip),
    .ext_fault(ext_fault), .int_fault(int_fault), .vbus_on(vbus_on));
  // ******************************
  // helpers
  // ******************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wait_run(input int n);
    for (i = 0; i < n && clock_run !== 1'b1; i++) @(posedge sys_clk);
  endtask
  // ******************************
  // monitor and timeout
  // ******************************
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check("unexpected read", 32'h1, 32'h0);
      else check("read data", avs_readdata, exp_q.pop_front());
    end
  end
  // ******************************
  // main sequence
  // ******************************
  initial begin
    wt(8);
    rst <= 1'b0;
    rd(hc_power_pkg::OFF_HW_CONFIG, 32'h0);
    rnd = lfsr(rnd);
    bus(1'b1, 4'h2, rnd);
    rd(4'h2, 32'h0);
    rd(hc_power_pkg::OFF_HW_CONFIG, 32'h0);
    for (int k = 0; k < 12; k++) begin
      if (k == 6) bus(1'b1, hc_power_pkg::OFF_HW_CONFIG, 32'h1400);
      rnd = lfsr(rnd);
      @(posedge sys_clk);
      ext_fault <= (k < 6) ? rnd[1:0] : ~rnd[1:0];
      int_fault <= (k < 6) ? ~rnd[1:0] : rnd[1:0];
      wt(6);
      check("vbus", {30'h0, vbus_on}, {30'h0, ~rnd[1:0]});
    end
    check("pulldown", {31'h0, internal_pulldown_on}, 32'h1);
    rd(hc_power_pkg::OFF_HW_CONFIG, 32'h1400);
    ext_fault <= 2'h0;
    int_fault <= 2'h0;
    bus(1'b1, hc_power_pkg::OFF_HW_CONFIG, 32'h0);
    wt(3);
    check("pulldown off", {31'h0, internal_pulldown_on}, 32'h0);
    bus(1'b1, hc_power_pkg::OFF_HOST_CTRL, 32'hC0);
    wt(3);
    check("suspended", {31'h0, host_suspended_out}, 32'h1);
    wt(SUSP + 10);
    check("clock stop", {31'h0, clock_run}, 32'h0);
    check("full host only", {31'h0, full_suspend}, 32'h0);
    device_suspended <= 1'b1;
    wt(6);
    check("full suspend", {31'h0, full_suspend}, 32'h1);
    check("regulator", {31'h0, regulator_power_down}, 32'h1);
    device_suspended <= 1'b0;
    host_wake_in <= 1'b1;
    wt(100);
    check("wake early", {31'h0, clock_run}, 32'h0);
    wait_run(hc_power_pkg::WAKE_UP_CYC + 20);
    check("wake clock", {31'h0, clock_run}, 32'h1);
    wt(20);
    rd(hc_power_pkg::OFF_PROC_INT, 32'h40);
    bus(1'b1, hc_power_pkg::OFF_PROC_INT, 32'h40);
    rd(hc_power_pkg::OFF_PROC_INT, 32'h0);
    wt(WLOW * 3);
    check("wake held", {31'h0, clock_run}, 32'h1);
    host_wake_in <= 1'b0;
    wt(WLOW + 10);
    check("wake lapse", {31'h0, clock_run}, 32'h0);
    check("back suspended", {31'h0, host_suspended_out}, 32'h1);
    chip_select_n <= 1'b0;
    wait_run(200);
    check("cs wake", {31'h0, clock_run}, 32'h1);
    usb_resume_in <= 1'b1;
    wt(10);
    usb_resume_in <= 1'b0;
    rd(hc_power_pkg::OFF_HOST_CTRL, 32'h40);
    rd(hc_power_pkg::OFF_EVENT_STAT, 32'h40);
    check("resume held", {31'h0, host_suspended_out}, 32'h1);
    bus(1'b1, hc_power_pkg::OFF_HOST_CTRL, 32'h80);
    chip_select_n <= 1'b1;
    wt(3);
    check("operational", {31'h0, host_suspended_out}, 32'h0);
    bus(1'b1, hc_power_pkg::OFF_HW_CONFIG, 32'h800);
    bus(1'b1, hc_power_pkg::OFF_HOST_CTRL, 32'hC0);
    wt(SUSP + 10);
    check("keep clock", {31'h0, clock_run}, 32'h1);
    bus(1'b1, hc_power_pkg::OFF_HOST_CTRL, 32'h0);
    wt(3);
    check("reset state", {31'h0, host_suspended_out}, 32'h0);
    // frozen state ignores a new fault until enable returns
    clk_en <= 1'b0;
    ext_fault <= 2'h3;
    wt(8);
    check("freeze", {30'h0, vbus_on}, 32'h3);
    clk_en <= 1'b1;
    wt(6);
    check("unfreeze", {30'h0, vbus_on}, 32'h0);
    ext_fault <= 2'h0;
    // mid-run reset clears the config again
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    rd(hc_power_pkg::OFF_HW_CONFIG, 32'h0);
    wt(4);
    close_out();
  end
endmodule // host_port_power_and_suspend_ctrl_tb
`default_nettype wire
